// *** core/adcsc_cfg.svh ***
// Offsets, field positions and reset values of the converter control block.
// Assumes inclusion by the package and the testbench.
`ifndef ADCSC_CFG_SVH
`define ADCSC_CFG_SVH
// ************************************************************
// Register byte offsets
// ************************************************************
`define ADCSC_OFF_CON1 8'h00
`define ADCSC_OFF_CON2 8'h04
`define ADCSC_OFF_STAT 8'h08
`define ADCSC_OFF_MASK 8'h0C
`define ADCSC_OFF_SCAN 8'h10
`define ADCSC_OFF_INSEL 8'h14
// ************************************************************
// Control one fields
// ************************************************************
`define ADCSC_C1_ON 15
`define ADCSC_C1_12B 10
`define ADCSC_C1_TRG_HI 7
`define ADCSC_C1_TRG_LO 5
`define ADCSC_C1_AUTO 2
`define ADCSC_C1_SAMPLE_ACTIVE 1
`define ADCSC_C1_DONE 0
// ************************************************************
// Control two fields
// ************************************************************
`define ADCSC_C2_REF_HI 15
`define ADCSC_C2_REF_LO 13
`define ADCSC_C2_SCAN 10
`define ADCSC_C2_CHN_HI 9
`define ADCSC_C2_CHN_LO 8
`define ADCSC_C2_HALF 7
`define ADCSC_C2_INT_HI 5
`define ADCSC_C2_INT_LO 2
`define ADCSC_C2_SPLIT 1
`define ADCSC_C2_ALT 0
// ************************************************************
// Status bits, select fields, codes, reset values
// ************************************************************
`define ADCSC_ST_SEQ 0
`define ADCSC_ST_DONE 1
`define ADCSC_SEL_B_LO 8
`define ADCSC_TRG_SW 3'h0
`define ADCSC_RST_REG 16'h0000
`define ADCSC_RST_SCAN 16'h0001
`endif

// *** core/adcsc_pkg.sv ***
// Types shared by the converter control block.
// Assumes the configuration header is on the include path.
`include "adcsc_cfg.svh"
package adcsc_pkg;
   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      ADCSC_IDLE = 3'b001,
      ADCSC_SAMPLE = 3'b010,
      ADCSC_CONVERT = 3'b100
   } adcsc_state_t;
endpackage : adcsc_pkg

// *** core/adcsc_ctrl.sv ***
// Sample and convert sequencer with APB register file and interrupt.
// Assumes a converter core that pulses conv_done once per conversion and
// a trigger pulse already chosen outside from the trigger source code.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Functional notes
// - Auto-start resamples after conversion, sets sample_active
// - Without auto-start, software write 1 starts sampling
// - sample_active reads 1 while acquiring, 0 holding
// - Trigger 000: software writes 0 to convert
// - Other trigger: hardware clears sample_active, converts
// - Done flag set at conversion end
// - Software clears done by 0; ops unaffected
// - Done flag cleared when conversion starts
// - Reference field selects supply or external refs
// - Interrupt after every interval plus one sequences
// - Split buffer alternates halves per interrupt
// - Alternate mode swaps input sets A and B
module adcsc_ctrl
   import adcsc_pkg::*;
#(
   parameter int NUM_INPUTS = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter core
   input wire logic trigger,
   input wire logic conv_done,
   output logic sample_active,
   output logic conv_start,
   output logic [3:0] channel_enable,
   output logic ref_pos_external,
   output logic ref_neg_external,
   output logic input_set_b,
   output logic [3:0] positive_input,
   output logic buffer_half_status,
   // Interrupt
   output logic irq
);
   // ************************************************************
   // Decoding helpers
   // ************************************************************
   function automatic logic [3:0] chan_mask(input logic [1:0] cnt, input logic twelve);
      logic [3:0] m;
      m = 4'h1;
      if (!twelve && cnt == 2'h1) begin
         m = 4'h3;
      end else if (!twelve && cnt[1]) begin
         m = 4'hF;
      end
      return m;
   endfunction : chan_mask
   function automatic logic [3:0] next_scan(input logic [3:0] cur, input logic [15:0] list);
      logic [3:0] n;
      logic found;
      n = cur;
      found = 1'b0;
      for (int i = 1; i <= NUM_INPUTS; i++) begin
         if (!found && list[4'(cur + i[3:0])]) begin
            n = 4'(cur + i[3:0]);
            found = 1'b1;
         end
      end
      return n;
   endfunction : next_scan
   // ************************************************************
   // Bus decode
   // ************************************************************
   logic acc;
   logic wr;
   logic wr_con1;
   logic wr_con2;
   logic wr_stat;
   logic wr_mask;
   logic wr_scan;
   logic wr_insel;
   logic mapped;
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;
   assign wr_con1 = wr && paddr == `ADCSC_OFF_CON1;
   assign wr_con2 = wr && paddr == `ADCSC_OFF_CON2;
   assign wr_stat = wr && paddr == `ADCSC_OFF_STAT;
   assign wr_mask = wr && paddr == `ADCSC_OFF_MASK;
   assign wr_scan = wr && paddr == `ADCSC_OFF_SCAN;
   assign wr_insel = wr && paddr == `ADCSC_OFF_INSEL;
   assign mapped = paddr == `ADCSC_OFF_CON1 || paddr == `ADCSC_OFF_CON2
      || paddr == `ADCSC_OFF_STAT || paddr == `ADCSC_OFF_MASK
      || paddr == `ADCSC_OFF_SCAN || paddr == `ADCSC_OFF_INSEL;
   // ************************************************************
   // Software settings
   // ************************************************************
   logic conv_on;
   logic twelve_bit_mode;
   logic [2:0] trigger_source;
   logic auto_sample_start;
   logic [2:0] reference_select;
   logic scan_enable;
   logic [1:0] channel_count;
   logic [3:0] interrupt_interval;
   logic split_buffer_mode;
   logic alternate_input_mode;
   logic [1:0] int_mask;
   logic [15:0] scan_list;
   logic [3:0] sel_a;
   logic [3:0] sel_b;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_on <= 1'b0;
         twelve_bit_mode <= 1'b0;
         trigger_source <= `ADCSC_TRG_SW;
         auto_sample_start <= 1'b0;
      end else if (wr_con1) begin
         conv_on <= pwdata[`ADCSC_C1_ON];
         twelve_bit_mode <= pwdata[`ADCSC_C1_12B];
         trigger_source <= pwdata[`ADCSC_C1_TRG_HI:`ADCSC_C1_TRG_LO];
         auto_sample_start <= pwdata[`ADCSC_C1_AUTO];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reference_select <= 3'h0;
         scan_enable <= 1'b0;
         channel_count <= 2'h0;
         interrupt_interval <= 4'h0;
         split_buffer_mode <= 1'b0;
         alternate_input_mode <= 1'b0;
      end else if (wr_con2) begin
         reference_select <= pwdata[`ADCSC_C2_REF_HI:`ADCSC_C2_REF_LO];
         scan_enable <= pwdata[`ADCSC_C2_SCAN];
         channel_count <= pwdata[`ADCSC_C2_CHN_HI:`ADCSC_C2_CHN_LO];
         interrupt_interval <= pwdata[`ADCSC_C2_INT_HI:`ADCSC_C2_INT_LO];
         split_buffer_mode <= pwdata[`ADCSC_C2_SPLIT];
         alternate_input_mode <= pwdata[`ADCSC_C2_ALT];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask <= 2'h0;
         scan_list <= `ADCSC_RST_SCAN;
         sel_a <= 4'h0;
         sel_b <= 4'h0;
      end else begin
         if (wr_mask) begin
            int_mask <= pwdata[1:0];
         end
         if (wr_scan) begin
            scan_list <= pwdata[15:0];
         end
         if (wr_insel) begin
            sel_a <= pwdata[3:0];
            sel_b <= pwdata[`ADCSC_SEL_B_LO +: 4];
         end
      end
   end
   // ************************************************************
   // Sample and convert sequencer
   // ************************************************************
   adcsc_state_t state;
   logic sw_start;
   logic sw_convert;
   logic hw_convert;
   logic go_convert;
   logic enter_sample;
   assign sw_start = wr_con1 && pwdata[`ADCSC_C1_SAMPLE_ACTIVE] && !pwdata[`ADCSC_C1_AUTO];
   assign sw_convert = wr_con1 && !pwdata[`ADCSC_C1_SAMPLE_ACTIVE]
      && trigger_source == `ADCSC_TRG_SW;
   assign hw_convert = trigger && trigger_source != `ADCSC_TRG_SW;
   assign go_convert = state == ADCSC_SAMPLE && (sw_convert || hw_convert);
   assign enter_sample = conv_on && ((state == ADCSC_IDLE && (auto_sample_start || sw_start))
      || (state == ADCSC_CONVERT && conv_done && auto_sample_start));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ADCSC_IDLE;
      end else if (!conv_on) begin
         state <= ADCSC_IDLE;
      end else begin
         case (state)
            ADCSC_IDLE: begin
               if (auto_sample_start || sw_start) begin
                  state <= ADCSC_SAMPLE;
               end
            end
            ADCSC_SAMPLE: begin
               if (go_convert) begin
                  state <= ADCSC_CONVERT;
               end
            end
            ADCSC_CONVERT: begin
               if (conv_done) begin
                  state <= auto_sample_start ? ADCSC_SAMPLE : ADCSC_IDLE;
               end
            end
            default: begin
               state <= ADCSC_IDLE;
            end
         endcase
      end
   end
   // ************************************************************
   // Done flag, sequence count, buffer half, input set, scan
   // ************************************************************
   logic done;
   logic [3:0] seq_cnt;
   logic seq_end;
   logic finish;
   assign finish = state == ADCSC_CONVERT && conv_done;
   assign seq_end = finish && seq_cnt == interrupt_interval;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done <= 1'b0;
      end else if (finish) begin
         done <= 1'b1;
      end else if (go_convert) begin
         done <= 1'b0;
      end else if (wr_con1 && !pwdata[`ADCSC_C1_DONE]) begin
         done <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_cnt <= 4'h0;
      end else if (seq_end) begin
         seq_cnt <= 4'h0;
      end else if (finish) begin
         seq_cnt <= seq_cnt + 4'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buffer_half_status <= 1'b0;
      end else if (!split_buffer_mode) begin
         buffer_half_status <= 1'b0;
      end else if (seq_end) begin
         buffer_half_status <= !buffer_half_status;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_set_b <= 1'b0;
      end else if (!alternate_input_mode) begin
         input_set_b <= 1'b0;
      end else if (finish) begin
         input_set_b <= !input_set_b;
      end
   end
   logic [3:0] scan_ptr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_ptr <= 4'h0;
      end else if (finish && scan_enable) begin
         scan_ptr <= next_scan(scan_ptr, scan_list);
      end
   end
   // ************************************************************
   // Converter core outputs
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_active <= 1'b0;
         conv_start <= 1'b0;
         channel_enable <= 4'h1;
         ref_pos_external <= 1'b0;
         ref_neg_external <= 1'b0;
         positive_input <= 4'h0;
      end else begin
         sample_active <= enter_sample
            || (conv_on && state == ADCSC_SAMPLE && !go_convert);
         conv_start <= go_convert;
         channel_enable <= chan_mask(channel_count, twelve_bit_mode);
         ref_pos_external <= !reference_select[2] && reference_select[0];
         ref_neg_external <= !reference_select[2] && reference_select[1];
         if (scan_enable) begin
            positive_input <= scan_ptr;
         end else begin
            positive_input <= input_set_b ? sel_b : sel_a;
         end
      end
   end
   // ************************************************************
   // Interrupt status
   // ************************************************************
   logic [1:0] int_stat;
   logic [1:0] int_set;
   assign int_set = {finish, seq_end};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat <= 2'h0;
      end else begin
         int_stat <= int_set | (int_stat & ~(wr_stat ? pwdata[1:0] : 2'h0));
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat & int_mask);
      end
   end
   // ************************************************************
   // APB answer
   // ************************************************************
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0000_0000;
      case (paddr)
         `ADCSC_OFF_CON1: begin
            rd_val[`ADCSC_C1_ON] = conv_on;
            rd_val[`ADCSC_C1_12B] = twelve_bit_mode;
            rd_val[`ADCSC_C1_TRG_HI:`ADCSC_C1_TRG_LO] = trigger_source;
            rd_val[`ADCSC_C1_AUTO] = auto_sample_start;
            rd_val[`ADCSC_C1_SAMPLE_ACTIVE] = state == ADCSC_SAMPLE;
            rd_val[`ADCSC_C1_DONE] = done;
         end
         `ADCSC_OFF_CON2: begin
            rd_val[`ADCSC_C2_REF_HI:`ADCSC_C2_REF_LO] = reference_select;
            rd_val[`ADCSC_C2_SCAN] = scan_enable;
            rd_val[`ADCSC_C2_CHN_HI:`ADCSC_C2_CHN_LO] = channel_count;
            rd_val[`ADCSC_C2_HALF] = buffer_half_status;
            rd_val[`ADCSC_C2_INT_HI:`ADCSC_C2_INT_LO] = interrupt_interval;
            rd_val[`ADCSC_C2_SPLIT] = split_buffer_mode;
            rd_val[`ADCSC_C2_ALT] = alternate_input_mode;
         end
         `ADCSC_OFF_STAT: begin
            rd_val[1:0] = int_stat;
         end
         `ADCSC_OFF_MASK: begin
            rd_val[1:0] = int_mask;
         end
         `ADCSC_OFF_SCAN: begin
            rd_val[15:0] = scan_list;
         end
         `ADCSC_OFF_INSEL: begin
            rd_val[3:0] = sel_a;
            rd_val[`ADCSC_SEL_B_LO +: 4] = sel_b;
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready && !pwrite) begin
            prdata <= rd_val;
         end
      end
   end

endmodule : adcsc_ctrl

// *** verification/adcsc_props.sv ***
// Port checker of the converter control block.
// Assumes binding to adcsc_ctrl; sees its ports only.
`timescale 1ns/1ps
module adcsc_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Converter core
   input wire logic trigger,
   input wire logic conv_done,
   input wire logic conv_start,
   input wire logic sample_active,
   input wire logic input_set_b,
   input wire logic buffer_half_status
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic apb_wr;
   assign apb_wr = psel && penable && pready && pwrite;
   // ************************************************************
   // Sequences
   // ************************************************************
   sequence s_access;
      psel && !penable ##1 psel && penable;
   endsequence
   sequence s_write_back;
      $past(apb_wr);
   endsequence
   // ************************************************************
   // Properties
   // ************************************************************
   a_one_wait: assert property (s_access |-> !pready ##1 pready)
      else $error("pready not one wait state after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_error_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_hold: assert property ($changed(prdata) |-> pready)
      else $error("prdata changed outside answer");
   a_start_ends_sample: assert property (conv_start |-> !sample_active && $past(sample_active))
      else $error("conversion start without end of sampling");
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("conv_start longer than one cycle");
   a_start_cause: assert property (conv_start |-> $past(trigger) or s_write_back)
      else $error("conversion start without trigger or write");
   a_half_on_done: assert property ($changed(buffer_half_status)
      |-> $past(conv_done) || $past(apb_wr, 2))
      else $error("buffer half changed without cause");
   a_alt_on_done: assert property ($rose(input_set_b) |-> $past(conv_done))
      else $error("input set changed without conversion");
endmodule : adcsc_props

bind adcsc_ctrl adcsc_props adcsc_props_i (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
   .pready, .pslverr, .trigger, .conv_done, .conv_start, .sample_active, .input_set_b,
   .buffer_half_status);

// *** verification/adcsc_core_model.sv ***
// Converter core model: answers each conversion start after a delay.
// Assumes one-cycle conv_start pulses from the control block.
`timescale 1ns/1ps
module adcsc_core_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic conv_start,
   input wire logic [7:0] delay,
   output logic conv_done
);
   logic [7:0] cnt;
   logic busy;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         conv_done <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         if (conv_start) begin
            busy <= 1'b1;
            cnt <= delay;
         end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            conv_done <= 1'b1;
         end else if (busy) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule : adcsc_core_model

// *** verification/testbench.sv ***
// Self-checking bench of the converter control block.
// Assumes the design, checker and core model are compiled before it.
`timescale 1ns/1ps
`include "adcsc_cfg.svh"
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic trigger = 1'b0, pready, pslverr, conv_done, sample_active, conv_start;
   logic ref_pos_external, ref_neg_external, input_set_b, buffer_half_status, irq, rerr;
   logic [7:0] paddr = 8'h00, delay = 8'h14;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic [3:0] channel_enable, positive_input;
   int n_errors = 0, compares = 0;
   localparam logic [31:0] c_on = 32'h1 << `ADCSC_C1_ON;
   localparam logic [31:0] c_sample_active = 32'h1 << `ADCSC_C1_SAMPLE_ACTIVE;
   localparam logic [31:0] c_done = 32'h1 << `ADCSC_C1_DONE;
   localparam logic [31:0] c_run = c_on | (32'h1 << `ADCSC_C1_TRG_LO) | (32'h1 << `ADCSC_C1_AUTO);
   adcsc_ctrl adcsc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .trigger, .conv_done, .sample_active, .conv_start, .channel_enable,
      .ref_pos_external, .ref_neg_external, .input_set_b, .positive_input,
      .buffer_half_status, .irq);
   adcsc_core_model adcsc_core_model_i (.pclk, .presetn, .conv_start, .delay, .conv_done);
   initial begin
      forever #4 pclk = ~pclk;
   end
   // ************************************************************
   // Tasks
   // ************************************************************
   task end_sim;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdata);
   endtask : rdc
   task cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask : cyc
   task wait_done;
      do begin
         @(posedge pclk);
      end while (conv_done !== 1'b1);
      cyc(3);
   endtask : wait_done
   task pulse_trigger;
      @(posedge pclk) trigger <= 1'b1;
      @(posedge pclk) trigger <= 1'b0;
      @(negedge pclk);
   endtask : pulse_trigger
   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
   initial begin
      logic [7:0] offs [6];
      logic [31:0] rv [6];
      offs = '{`ADCSC_OFF_CON1, `ADCSC_OFF_CON2, `ADCSC_OFF_STAT, `ADCSC_OFF_MASK,
         `ADCSC_OFF_SCAN, `ADCSC_OFF_INSEL};
      rv = '{32'h0, 32'h0, 32'h0, 32'h0, 32'(`ADCSC_RST_SCAN), 32'h0};
      cyc(5);
      presetn <= 1'b1;
      chk("channel reset", 32'h1, 32'(channel_enable));
      for (int i = 0; i < 6; i++) rdc("reset value", offs[i], rv[i]);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'h1, 32'(rerr));
      chk("unmapped data", 32'h0, rdata);
      $display("test reset done");
      wr(`ADCSC_OFF_CON1, c_on);
      cyc(3);
      chk("idle sample", 32'h0, 32'(sample_active));
      wr(`ADCSC_OFF_CON1, c_on | c_sample_active);
      cyc(3);
      chk("sw sample", 32'h1, 32'(sample_active));
      rdc("con1 sampling", `ADCSC_OFF_CON1, c_on | c_sample_active);
      wr(`ADCSC_OFF_CON1, c_on);
      wait_done();
      rdc("con1 done", `ADCSC_OFF_CON1, c_on | c_done);
      chk("holding", 32'h0, 32'(sample_active));
      wr(`ADCSC_OFF_CON1, c_on);
      rdc("done cleared", `ADCSC_OFF_CON1, c_on);
      wr(`ADCSC_OFF_CON1, c_on | c_done);
      rdc("done not set", `ADCSC_OFF_CON1, c_on);
      $display("test manual done");
      for (int v = 0; v < 8; v++) begin
         wr(`ADCSC_OFF_CON2, 32'(v) << `ADCSC_C2_REF_LO);
         cyc(2);
         chk("reference", {v == 1 || v == 3, v == 2 || v == 3},
            {ref_pos_external, ref_neg_external});
      end
      for (int c = 0; c < 4; c++) begin
         wr(`ADCSC_OFF_CON2, 32'(c) << `ADCSC_C2_CHN_LO);
         cyc(2);
         chk("channels", (c == 0) ? 32'h1 : (c == 1) ? 32'h3 : 32'hF, 32'(channel_enable));
      end
      wr(`ADCSC_OFF_CON1, 32'h1 << `ADCSC_C1_12B);
      cyc(2);
      chk("channels twelve", 32'h1, 32'(channel_enable));
      $display("test fields done");
      rdc("status manual", `ADCSC_OFF_STAT, 32'h3);
      wr(`ADCSC_OFF_STAT, 32'h3);
      wr(`ADCSC_OFF_INSEL, 32'h0903);
      wr(`ADCSC_OFF_MASK, 32'h1);
      wr(`ADCSC_OFF_CON2, 32'h7);
      wr(`ADCSC_OFF_CON1, c_run);
      cyc(3);
      chk("auto sample", 32'h1, 32'(sample_active));
      for (int i = 1; i < 3; i++) begin
         pulse_trigger();
         chk("conv start", 32'h1, 32'(conv_start));
         chk("trigger hold", 32'h0, 32'(sample_active));
         rdc("done at start", `ADCSC_OFF_CON1, c_run);
         wait_done();
         chk("resample", 32'h1, 32'(sample_active));
         rdc("done set", `ADCSC_OFF_CON1, c_run | c_sample_active | c_done);
         chk("input set", 32'(i == 1), 32'(input_set_b));
         chk("positive input", (i == 1) ? 32'h9 : 32'h3, 32'(positive_input));
         chk("buffer half", 32'(i == 2), 32'(buffer_half_status));
         chk("interval irq", 32'(i == 2), 32'(irq));
      end
      rdc("half bit", `ADCSC_OFF_CON2, 32'h87);
      wr(`ADCSC_OFF_STAT, 32'h1);
      cyc(3);
      chk("irq cleared", 32'h0, 32'(irq));
      rdc("status", `ADCSC_OFF_STAT, 32'h2);
      wr(`ADCSC_OFF_MASK, 32'h2);
      cyc(3);
      chk("irq unmasked", 32'h1, 32'(irq));
      wr(`ADCSC_OFF_MASK, 32'h0);
      cyc(3);
      chk("irq masked", 32'h0, 32'(irq));
      wr(`ADCSC_OFF_CON2, 32'h0);
      cyc(2);
      chk("half forced", 32'h0, 32'(buffer_half_status));
      wr(`ADCSC_OFF_SCAN, 32'h5);
      wr(`ADCSC_OFF_CON2, 32'h1 << `ADCSC_C2_SCAN);
      for (int j = 1; j < 3; j++) begin
         pulse_trigger();
         wait_done();
         chk("scan input", (j == 1) ? 32'h2 : 32'h0, 32'(positive_input));
      end
      wr(`ADCSC_OFF_CON1, 32'h0);
      $display("test sequence done");
      end_sim();
   end
endmodule : testbench
